/* File: logic/can_mob_pkg.sv */
// Purpose: Shared constants and carriers for the message object mask, stamp and data block
// Assumes: APB word addresses, 8-bit registers in the low byte lane
// Notes: Mask and tag words share one 32-bit layout, bit 31 is the top identifier bit
package can_mob_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_PAGE = 8'h00;
    localparam logic [7:0] OFS_MASK_HIGH = 8'h04;
    localparam logic [7:0] OFS_MASK_2 = 8'h08;
    localparam logic [7:0] OFS_MASK_3 = 8'h0c;
    localparam logic [7:0] OFS_MASK_LOW = 8'h10;
    localparam logic [7:0] OFS_STAMP_LOW = 8'h14;
    localparam logic [7:0] OFS_STAMP_HIGH = 8'h18;
    localparam logic [7:0] OFS_DATA_WIN = 8'h1c;
    localparam logic [7:0] OFS_BT_PRESCALE = 8'h20;
    localparam logic [7:0] OFS_BT_SYNC_PROP = 8'h24;
    localparam logic [7:0] OFS_BT_PHASES = 8'h28;
    localparam logic [7:0] OFS_CONTROL = 8'h2c;
    // Values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_STAMP = 16'h0000;
    // Page register fields
    localparam int PAGE_IDX_LSB = 0;
    localparam int PAGE_AINC_BIT = 3;
    localparam int PAGE_OBJ_LSB = 4;
    // Bit timing and control fields
    localparam int BT_BRP_LSB = 1;
    localparam int BT_PRS_LSB = 1;
    localparam int BT_SJW_LSB = 5;
    localparam int BT_PH1_LSB = 1;
    localparam int BT_PH2_LSB = 4;
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_RXEN_BIT = 1;
    // Comparison enables per layout: identifier, remote request and extension flag bits; last data window index
    localparam logic [31:0] STD_CMP_BITS = 32'hffe0_0005;
    localparam logic [31:0] EXT_CMP_BITS = 32'hffff_fffd;
    localparam logic [2:0] IDX_LAST = 3'h7;

    // Received frame header, one-cycle valid
    typedef struct packed {
        logic valid;
        logic [28:0] ident;
        logic rtr;
        logic ide;
    } rx_frame_type;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;
endpackage

/* File: logic/obj_data_ram.sv */
// Purpose: Data byte store for all message objects
// Assumes: One write or read address per cycle
// Notes: Read data come from a register, one cycle after the address
`timescale 1ns/100ps
module obj_data_ram
    import can_mob_pkg::*;
#(
    parameter int ADDR_W = 7,
    parameter int WIDTH = 8
)
(
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [0:(2**ADDR_W)-1];

    // Contents have no reset, like any RAM
    always_ff @(posedge clk_sys)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule // obj_data_ram

/* File: logic/can_mob_mask_stamp_data.sv */
// Purpose: Acceptance mask, frame time stamp, data window and bit timing of message objects
// Assumes: APB slave at 10 MHz clk_sys, frame header from the protocol engine on same clock
// Notes: Every APB transfer takes two access cycles; read data and pready come from flops
//
// Function
// - Standard layout: mask bits 31:21 zero force pass, one compares identifier bit.
// - Extended layout: mask bits 31:3 act per bit on the 29-bit identifier.
// - Mask bit 2 gates the remote-request comparison.
// - Mask bit 0 gates comparison of extension flag against object setting.
// - Read-only 16-bit time stamp, low byte bits 7:0, high byte 15:8.
// - Data window reads and writes the byte at selected object and index.
// - After a page write the window shows the newly selected byte at once.
// - With auto-increment on, each window access advances the index by one.
// - The index counts modulo 8, wrapping 7 to 0.
// - Bit time is sync, propagation and two phase segments, in quanta; jump width is not counted.
// - Reserved tag positions take no part in acceptance.
`timescale 1ns/100ps
module can_mob_mask_stamp_data
    import can_mob_pkg::*;
#(
    parameter int OBJ_W = 4
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rx_frame_type rx_frame,
    input wire logic [31:0] ident_tag_regs,
    input wire logic obj_ide,
    output logic accept_q,
    output logic bit_tick_q,
    output logic sample_tick_q
);
    // Segment length in quanta from a 3-bit field
    function automatic logic [4:0] seg_len(input logic [2:0] field);
        seg_len = {2'b00, field} + 5'd1;
    endfunction

    apb_req_type req;
    logic [7:0] page_q;
    logic [7:0] id_mask_byte_high;
    logic [7:0] id_mask_byte_2;
    logic [7:0] id_mask_byte_3;
    logic [7:0] id_mask_byte_low_flags;
    logic [7:0] bit_timing_prescale;
    logic [7:0] bit_timing_sync_prop;
    logic [7:0] bit_timing_phases;
    logic [7:0] control_q;
    logic [15:0] frame_stamp_count;
    logic [15:0] stamp_run_q;
    logic [5:0] tq_cnt_q;
    logic [4:0] q_cnt_q;
    logic [7:0] object_data_byte;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // Bus request travels as one bundle
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // Transfer decode: a transfer ends when pready is already up in the access phase
    wire xfer_done = req.psel && req.penable && pready_q;
    wire first_access = req.psel && req.penable && !pready_q;
    wire wr_done = xfer_done && req.pwrite;
    wire hit_page = req.paddr == OFS_PAGE;
    wire hit_m1 = req.paddr == OFS_MASK_HIGH;
    wire hit_m2 = req.paddr == OFS_MASK_2;
    wire hit_m3 = req.paddr == OFS_MASK_3;
    wire hit_m4 = req.paddr == OFS_MASK_LOW;
    wire hit_sl = req.paddr == OFS_STAMP_LOW;
    wire hit_sh = req.paddr == OFS_STAMP_HIGH;
    wire hit_win = req.paddr == OFS_DATA_WIN;
    wire hit_bt1 = req.paddr == OFS_BT_PRESCALE;
    wire hit_bt2 = req.paddr == OFS_BT_SYNC_PROP;
    wire hit_bt3 = req.paddr == OFS_BT_PHASES;
    wire hit_ctl = req.paddr == OFS_CONTROL;
    wire hit_any = hit_page || hit_m1 || hit_m2 || hit_m3 || hit_m4 || hit_sl || hit_sh
        || hit_win || hit_bt1 || hit_bt2 || hit_bt3 || hit_ctl;
    // Stamp registers are read-only, so a write there is refused
    wire bad_access = !hit_any || (req.pwrite && (hit_sl || hit_sh));

    // Page fields and data window addressing
    wire [2:0] data_idx = page_q[PAGE_IDX_LSB +: 3];
    wire auto_inc = page_q[PAGE_AINC_BIT];
    wire [OBJ_W-1:0] obj_sel = page_q[PAGE_OBJ_LSB +: OBJ_W];
    wire [OBJ_W+2:0] win_addr = {obj_sel, data_idx};
    wire win_done = xfer_done && hit_win;
    wire win_we = wr_done && hit_win;
    wire [2:0] idx_next = data_idx + 3'd1;

    // Next page value: software write first, else auto-increment after a window access
    logic [7:0] page_d;
    always_comb
    begin
        page_d = page_q;
        if (wr_done && hit_page)
        begin
            page_d = req.pwdata[7:0];
        end
        else if (win_done && auto_inc)
        begin
            page_d[PAGE_IDX_LSB +: 3] = idx_next;
        end
    end

    // Read multiplexer, upper bits and unmapped places read as zero
    wire [7:0] rd_byte = hit_page ? page_q
        : hit_m1 ? id_mask_byte_high
        : hit_m2 ? id_mask_byte_2
        : hit_m3 ? id_mask_byte_3
        : hit_m4 ? id_mask_byte_low_flags
        : hit_sl ? frame_stamp_count[7:0]
        : hit_sh ? frame_stamp_count[15:8]
        : hit_win ? object_data_byte
        : hit_bt1 ? bit_timing_prescale
        : hit_bt2 ? bit_timing_sync_prop
        : hit_bt3 ? bit_timing_phases
        : hit_ctl ? control_q
        : 8'h00;

    // Bus answer: one wait state gives the data RAM time after an index change
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= first_access;
            prdata_q <= first_access && !req.pwrite ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr_q <= first_access && bad_access;
        end
    end

    // Software registers; nothing but a bus write touches the mask bytes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            page_q <= RST_BYTE;
            id_mask_byte_high <= RST_BYTE;
            id_mask_byte_2 <= RST_BYTE;
            id_mask_byte_3 <= RST_BYTE;
            id_mask_byte_low_flags <= RST_BYTE;
            bit_timing_prescale <= RST_BYTE;
            bit_timing_sync_prop <= RST_BYTE;
            bit_timing_phases <= RST_BYTE;
            control_q <= RST_BYTE;
        end
        else
        begin
            page_q <= page_d;
            if (wr_done && hit_m1) id_mask_byte_high <= req.pwdata[7:0];
            if (wr_done && hit_m2) id_mask_byte_2 <= req.pwdata[7:0];
            if (wr_done && hit_m3) id_mask_byte_3 <= req.pwdata[7:0];
            if (wr_done && hit_m4) id_mask_byte_low_flags <= req.pwdata[7:0];
            if (wr_done && hit_bt1) bit_timing_prescale <= req.pwdata[7:0];
            if (wr_done && hit_bt2) bit_timing_sync_prop <= req.pwdata[7:0];
            if (wr_done && hit_bt3) bit_timing_phases <= req.pwdata[7:0];
            if (wr_done && hit_ctl) control_q <= req.pwdata[7:0];
        end
    end

    // Data bytes of all objects; window follows the page register a cycle later
    obj_data_ram #(
        .ADDR_W(OBJ_W + 3),
        .WIDTH(8)
    ) u_ram (
        .clk_sys(clk_sys),
        .we(win_we),
        .addr(win_addr),
        .wdata(req.pwdata[7:0]),
        .rdata_q(object_data_byte)
    );

    // Acceptance: received header packed in the mask layout, reserved bits dropped
    wire ext_layout = control_q[CTRL_EXT_BIT];
    wire rx_enable = control_q[CTRL_RXEN_BIT];
    wire [31:0] mask_word = {id_mask_byte_high, id_mask_byte_2, id_mask_byte_3,
        id_mask_byte_low_flags};
    wire [31:0] rx_word = ext_layout ?
        {rx_frame.ident, rx_frame.rtr, 1'b0, rx_frame.ide} :
        {rx_frame.ident[10:0], 18'h0_0000, rx_frame.rtr, 1'b0, rx_frame.ide};
    wire [31:0] tag_word = {ident_tag_regs[31:1], obj_ide};
    wire [31:0] cmp_en = mask_word & (ext_layout ? EXT_CMP_BITS : STD_CMP_BITS);
    wire frame_hit = ((rx_word ^ tag_word) & cmp_en) == 32'h0000_0000;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            accept_q <= 1'b0;
        end
        else
        begin
            accept_q <= rx_frame.valid && rx_enable && frame_hit;
        end
    end

    // Bit timing: quantum = prescale bits 6:1 plus 1 clocks, bit = sync + prop + phase1 + phase2
    // Jump width is held for the resynchronising engine; nothing here re-times edges
    wire [5:0] brp = bit_timing_prescale[BT_BRP_LSB +: 6];
    wire [4:0] prs_len = seg_len(bit_timing_sync_prop[BT_PRS_LSB +: 3]);
    wire [4:0] ph1_len = seg_len(bit_timing_phases[BT_PH1_LSB +: 3]);
    wire [4:0] ph2_len = seg_len(bit_timing_phases[BT_PH2_LSB +: 3]);
    wire [4:0] bit_len = 5'd1 + prs_len + ph1_len + ph2_len;
    wire [4:0] sample_q_idx = prs_len + ph1_len;
    wire tq_tick = tq_cnt_q == brp;
    wire bit_end = tq_tick && q_cnt_q == bit_len - 5'd1;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tq_cnt_q <= 6'h00;
            q_cnt_q <= 5'h00;
            bit_tick_q <= 1'b0;
            sample_tick_q <= 1'b0;
        end
        else
        begin
            tq_cnt_q <= tq_tick ? 6'h00 : tq_cnt_q + 6'h01;
            if (tq_tick)
            begin
                q_cnt_q <= bit_end ? 5'h00 : q_cnt_q + 5'h01;
            end
            bit_tick_q <= bit_end;
            sample_tick_q <= tq_tick && q_cnt_q == sample_q_idx;
        end
    end

    // Free bit-time counter wraps at 65535; a frame captures it into the stamp
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            stamp_run_q <= RST_STAMP;
            frame_stamp_count <= RST_STAMP;
        end
        else
        begin
            if (bit_end)
            begin
                stamp_run_q <= stamp_run_q + 16'h0001;
            end
            if (rx_frame.valid)
            begin
                frame_stamp_count <= stamp_run_q;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Checks beside the logic
    a_mask_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_done |=> $stable(mask_word))
        else $error("mask changed without a bus write");
    a_std_top_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_frame.valid && !ext_layout && mask_word[31]
        && rx_frame.ident[10] != ident_tag_regs[31] |=> !accept_q)
        else $error("standard identifier mismatch accepted");
    a_ext_low_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_frame.valid && ext_layout && mask_word[3]
        && rx_frame.ident[0] != ident_tag_regs[3] |=> !accept_q)
        else $error("extended identifier mismatch accepted");
    a_rtr_compare: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_frame.valid && mask_word[2] && rx_frame.rtr != ident_tag_regs[2] |=> !accept_q)
        else $error("remote request mismatch accepted");
    a_ide_compare: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_frame.valid && mask_word[0] && rx_frame.ide != obj_ide |=> !accept_q)
        else $error("extension flag mismatch accepted");
    a_open_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_frame.valid && rx_enable && mask_word == 32'h0000_0000 |=> accept_q)
        else $error("fully open mask rejected a frame");
    a_reserved_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_frame.valid && rx_enable && !ext_layout
        && rx_frame.ident[10:0] == ident_tag_regs[31:21] && rx_frame.rtr == ident_tag_regs[2]
        && rx_frame.ide == obj_ide |=> accept_q)
        else $error("reserved positions affected acceptance");
    a_index_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        win_done && auto_inc && !(wr_done && hit_page) |=> data_idx == $past(idx_next))
        else $error("index did not advance");
    a_index_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
        win_done && auto_inc && data_idx == IDX_LAST |=> data_idx == 3'h0)
        else $error("index did not wrap to zero");
    a_page_show: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_done && hit_page |=> win_addr == {$past(req.pwdata[PAGE_OBJ_LSB +: OBJ_W]),
        $past(req.pwdata[PAGE_IDX_LSB +: 3])})
        else $error("window not repointed by page write");
    a_stamp_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rx_frame.valid |=> frame_stamp_count == $past(stamp_run_q))
        else $error("stamp not captured on frame");
    a_bit_sample: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_tick_q |-> !bit_tick_q && $past(q_cnt_q) == $past(prs_len + ph1_len))
        else $error("sample point fell on bit end");
endmodule // can_mob_mask_stamp_data

/* File: sim/can_frame_source.sv */
// Purpose: Far-side model, received frame headers and the object tag word
// Assumes: Headers arrive on clk_sys as one-cycle pulses
// Notes: Idle header bits are inverted so stale values never look valid
`timescale 1ns/100ps
module can_frame_source
    import can_mob_pkg::*;
(
    input wire logic clk_sys,
    output rx_frame_type rx_frame,
    output logic [31:0] ident_tag_regs,
    output logic obj_ide
);
    // Quiet bus at time zero
    initial
    begin
        rx_frame = '0;
        ident_tag_regs = 32'h0000_0000;
        obj_ide = 1'b0;
    end

    // Tag word and extension setting are plain levels
    task automatic set_tag(input logic [31:0] tag, input logic ide);
        @(posedge clk_sys);
        ident_tag_regs <= tag;
        obj_ide <= ide;
    endtask

    // One header per call, then the lines are scrambled
    task automatic send(input logic [28:0] id, input logic rtr, input logic ide);
        @(posedge clk_sys);
        rx_frame <= '{valid: 1'b1, ident: id, rtr: rtr, ide: ide};
        @(posedge clk_sys);
        rx_frame <= '{valid: 1'b0, ident: ~id, rtr: ~rtr, ide: ~ide};
    endtask
endmodule // can_frame_source

/* File: sim/can_mob_mask_stamp_data_bench.sv */
// Purpose: Register-level bench for mask, stamp, data window and bit timing
// Assumes: APB master in this file, frame source model on the far side
// Notes: Bit timing set to one clock per quantum so counts stay short
`timescale 1ns/100ps
module can_mob_mask_stamp_data_bench;
    import can_mob_pkg::*;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, ident_tag_regs, rd;
    logic obj_ide, accept_q, bit_tick_q, sample_tick_q;
    logic [15:0] st0, st1;
    rx_frame_type rx_frame;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int n;

    can_mob_mask_stamp_data DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame(rx_frame),
        .ident_tag_regs(ident_tag_regs), .obj_ide(obj_ide), .accept_q(accept_q),
        .bit_tick_q(bit_tick_q), .sample_tick_q(sample_tick_q));
    can_frame_source src (.clk_sys(clk_sys), .rx_frame(rx_frame),
        .ident_tag_regs(ident_tag_regs), .obj_ide(obj_ide));

    // 10 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, {24'h0, exp});
    endtask

    // Whole mask word, top byte first
    task automatic set_mask(input logic [31:0] m);
        wr(OFS_MASK_HIGH, m[31:24]);
        wr(OFS_MASK_2, m[23:16]);
        wr(OFS_MASK_3, m[15:8]);
        wr(OFS_MASK_LOW, m[7:0]);
    endtask

    // Accept pulse is looked at in the cycle after the header
    task automatic rx(input logic [28:0] id, input logic r, input logic e, input logic exp);
        src.send(id, r, e);
        @(negedge clk_sys);
        check({31'h0, accept_q}, {31'h0, exp});
    endtask

    task automatic rd_stamp(output logic [15:0] s);
        apb(1'b0, OFS_STAMP_LOW, 32'h0);
        s[7:0] = rd[7:0];
        apb(1'b0, OFS_STAMP_HIGH, 32'h0);
        s[15:8] = rd[7:0];
    endtask

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values, read-only stamp and an unmapped place
        rd_chk(OFS_MASK_HIGH, RST_BYTE);
        rd_chk(OFS_STAMP_HIGH, RST_STAMP[15:8]);
        wr(OFS_STAMP_LOW, 8'h5a);
        check({31'h0, err}, 32'h1);
        rd_chk(OFS_STAMP_LOW, RST_STAMP[7:0]);
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // 16 quanta: prop 7, phase 4 and 4, sample at 12
        wr(OFS_BT_PRESCALE, 8'h00);
        wr(OFS_BT_SYNC_PROP, 8'h0c);
        wr(OFS_BT_PHASES, 8'h36);
        rd_chk(OFS_BT_PHASES, 8'h36);
        n = 0;
        do @(negedge clk_sys); while (bit_tick_q !== 1'b1 && ++n < 100);
        n = 0;
        do @(negedge clk_sys); while (sample_tick_q !== 1'b1 && ++n < 100);
        check(n + 1, 12);
        // The sample edge itself ended the loop without a count
        n = n + 1;
        do @(negedge clk_sys); while (bit_tick_q !== 1'b1 && ++n < 100);
        check(n + 1, 16);
        // Two headers 80 clocks apart must stamp five bit times apart
        fork
            begin
                src.send(29'h0, 1'b0, 1'b0);
                repeat (78) @(posedge clk_sys);
                src.send(29'h0, 1'b0, 1'b0);
            end
            begin
                repeat (2) @(posedge clk_sys);
                rd_stamp(st0);
            end
        join
        rd_stamp(st1);
        check({16'h0, st1 - st0}, 32'h5);
        // Standard layout, reception on; reserved mask bits written as zero
        wr(OFS_CONTROL, 8'h02);
        set_mask(STD_CMP_BITS);
        src.set_tag({11'h123, 18'h0, 3'b000}, 1'b0);
        rx(29'h123, 1'b0, 1'b0, 1'b1);
        rx(29'h122, 1'b0, 1'b0, 1'b0);
        rx(29'h523, 1'b0, 1'b0, 1'b0);
        rx(29'h123, 1'b1, 1'b0, 1'b0);
        rx(29'h123, 1'b0, 1'b1, 1'b0);
        src.set_tag({11'h123, 18'h3ffff, 3'b010}, 1'b0);
        rx(29'h123, 1'b0, 1'b0, 1'b1);
        // Lowest id bit, remote and extension comparisons forced true
        set_mask(32'hffc0_0000);
        rx(29'h122, 1'b1, 1'b1, 1'b1);
        rd_chk(OFS_MASK_2, 8'hc0);
        // Fully open mask takes any header
        set_mask(32'h0000_0000);
        rx(29'h7ff, 1'b1, 1'b1, 1'b1);
        // Extended layout, all 29 identifier bits compared
        wr(OFS_CONTROL, 8'h03);
        set_mask(EXT_CMP_BITS);
        src.set_tag({29'h0abc_def1, 3'b000}, 1'b1);
        rx(29'h0abc_def1, 1'b0, 1'b1, 1'b1);
        rx(29'h0abc_def0, 1'b0, 1'b1, 1'b0);
        rx(29'h1abc_def1, 1'b0, 1'b1, 1'b0);
        rx(29'h0abc_def1, 1'b0, 1'b0, 1'b0);
        wr(OFS_CONTROL, 8'h01);
        rx(29'h0abc_def1, 1'b0, 1'b1, 1'b0);
        rd_chk(OFS_MASK_LOW, 8'hfd);
        // Object 2 from index 6 with auto-increment, wrapping past 7
        wr(OFS_PAGE, 8'h2e);
        for (int i = 0; i < 4; i++)
            wr(OFS_DATA_WIN, 8'ha0 + 8'(i));
        wr(OFS_PAGE, 8'h3e);
        wr(OFS_DATA_WIN, 8'h55);
        wr(OFS_PAGE, 8'h2e);
        for (int i = 0; i < 4; i++)
            rd_chk(OFS_DATA_WIN, 8'ha0 + 8'(i));
        rd_chk(OFS_PAGE, 8'h2a);
        // Auto-increment off: index stays put
        wr(OFS_PAGE, 8'h27);
        rd_chk(OFS_DATA_WIN, 8'ha1);
        rd_chk(OFS_DATA_WIN, 8'ha1);
        wr(OFS_PAGE, 8'h3e);
        rd_chk(OFS_DATA_WIN, 8'h55);
        tally_and_finish();
    end
endmodule // can_mob_mask_stamp_data_bench
